//--- rtl/adc_reset_device.sv
`timescale 1ns/1ps
module adc_reset_device (
    input wire logic clk,
    input wire logic rst,
    adc_reset_if.device link,
    input wire logic [15:0] analog_code,
    output logic [11:0] cfg_word,
    output logic [15:0] result,
    output logic result_valid,
    output logic core_reset,
    output logic conversion_clock
);
    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic por_done_ff;
    logic soft_req_ff;
    logic [11:0] cfg_ff;

    // rst models power application; por_done drops on it
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= link.reset_n_line;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            por_done_ff <= 1'b0;
        end else begin
            por_done_ff <= 1'b1;
        end
    end

    // a 25ns low pulse spans several 4ns edges, so the two-stage sync always sees it
    assign core_reset = !por_done_ff || !pin_sync_ff || soft_req_ff;

    // ------------------------------------------------------------
    // serial configuration write
    // ------------------------------------------------------------
    logic [4:0] bit_cnt_ff;
    logic [11:0] shreg_ff;
    logic frame_d_ff;
    logic first_access_ff;
    logic [15:0] out_sh_ff;
    logic sdo_ff;

    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            bit_cnt_ff <= '0;
            shreg_ff <= '0;
        end else if (link.frame_select_line) begin
            bit_cnt_ff <= '0;
        end else if (link.shift_strobe && bit_cnt_ff != 5'h1F) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            shreg_ff <= {shreg_ff[10:0], link.serial_in_line};
        end
    end

    always_ff @(posedge clk) begin
        frame_d_ff <= rst ? 1'b1 : link.frame_select_line;
    end

    wire frame_end = link.frame_select_line && !frame_d_ff;
    wire cfg_write = frame_end && bit_cnt_ff == 5'(adc_reset_pkg::CFG_W);

    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            cfg_ff <= adc_reset_pkg::CFG_DEFAULT;
            soft_req_ff <= 1'b0;
        end else if (cfg_write) begin
            cfg_ff <= shreg_ff;
            soft_req_ff <= !shreg_ff[adc_reset_pkg::SOFT_RESET_POS];
        end
    end
    assign cfg_word = cfg_ff;

    // ------------------------------------------------------------
    // conversion clock and successive approximation
    // ------------------------------------------------------------
    logic [3:0] div_ff;
    logic conversion_clock_ff;
    logic busy_ff;
    logic [4:0] sar_idx_ff;
    logic [15:0] trial_ff;
    logic [15:0] result_ff;
    logic valid_ff;

    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            div_ff <= '0;
            conversion_clock_ff <= 1'b0;
        end else if (div_ff == 4'(adc_reset_pkg::CONV_CLK_DIV - 1)) begin
            div_ff <= '0;
            conversion_clock_ff <= !conversion_clock_ff;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign conversion_clock = conversion_clock_ff;
    wire conversion_clock_tick = conversion_clock_ff && div_ff == 4'(adc_reset_pkg::CONV_CLK_DIV - 1);

    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            busy_ff <= 1'b0;
            sar_idx_ff <= '0;
            trial_ff <= '0;
            result_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            if (!busy_ff && !link.conversion_start_strobe) begin
                busy_ff <= 1'b1;
                sar_idx_ff <= 5'h0F;
                trial_ff <= 16'h8000;
            end else if (busy_ff && conversion_clock_tick) begin
                // one decision per conversion clock period
                if (analog_code < trial_ff) begin
                    trial_ff[sar_idx_ff[3:0]] <= 1'b0;
                end
                if (sar_idx_ff == 5'h00) begin
                    busy_ff <= 1'b0;
                    valid_ff <= 1'b1;
                    result_ff <= (analog_code < trial_ff) ? trial_ff & ~16'h0001 : trial_ff;
                end else begin
                    trial_ff[sar_idx_ff[3:0] - 4'h1] <= 1'b1;
                    sar_idx_ff <= sar_idx_ff - 5'h01;
                end
            end
        end
    end
    assign result = result_ff;
    assign result_valid = valid_ff;

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            first_access_ff <= 1'b1;
        end else if (frame_end) begin
            first_access_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            out_sh_ff <= 16'hFFFF;
            sdo_ff <= 1'b1;
        end else if (link.frame_select_line) begin
            // msb already stands on the pin, so the shifter starts one bit further on
            out_sh_ff <= first_access_ff ? 16'hFFFF : {result_ff[14:0], 1'b0};
            sdo_ff <= first_access_ff ? 1'b1 : result_ff[15];
        end else if (link.shift_strobe) begin
            sdo_ff <= out_sh_ff[15];
            out_sh_ff <= {out_sh_ff[14:0], first_access_ff};
        end
    end
    assign link.serial_out_line = sdo_ff;
endmodule // adc_reset_device

//--- rtl/adc_reset_pkg.sv
package adc_reset_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RESET_PIN_MIN_NS = 25;
    localparam int RESET_PIN_MIN_CYC =
        (RESET_PIN_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVERY_US = 2;
    localparam int RECOVERY_CYC =
        (RECOVERY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CONV_CLK_KHZ = 12000;
    localparam int CONV_CLK_DIV = (250000 / CONV_CLK_KHZ) / 2;

    // ------------------------------------------------------------
    // configuration word and result
    // ------------------------------------------------------------
    localparam int CFG_W = 12;
    localparam int RESULT_W = 16;
    localparam int SOFT_RESET_POS = 0;
    localparam logic [11:0] CFG_DEFAULT = 12'hFFF;
    localparam int CNT_W = 12;

endpackage

//--- rtl/adc_reset_if.sv
`timescale 1ns/1ps
interface adc_reset_if;
    logic reset_n_line;
    logic frame_select_line;
    logic serial_in_line;
    logic serial_out_line;
    logic conversion_start_strobe;
    logic shift_strobe;

    modport device (
        input reset_n_line,
        input frame_select_line,
        input serial_in_line,
        input conversion_start_strobe,
        input shift_strobe,
        output serial_out_line
    );
    modport host (
        output reset_n_line,
        output frame_select_line,
        output serial_in_line,
        output conversion_start_strobe,
        output shift_strobe,
        input serial_out_line
    );
endinterface

//--- rtl/adc_reset_host.sv
`timescale 1ns/1ps
module adc_reset_host (
    input wire logic clk,
    input wire logic rst,
    adc_reset_if.host link,
    input wire logic hw_reset_req,
    input wire logic cfg_req,
    input wire logic [11:0] cfg_data,
    input wire logic convert_req,
    output logic ready,
    output logic [11:0] read_data
);
    typedef enum logic [2:0] {S_RECOVER, S_PIN, S_IDLE, S_SHIFT, S_END} state_e;
    state_e state_ff;
    logic [11:0] cnt_ff;
    logic [11:0] tx_ff;
    logic [11:0] rx_ff;
    logic conv_ff;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= S_RECOVER;
            cnt_ff <= '0;
            tx_ff <= '0;
            rx_ff <= '0;
        end else begin
            unique case (state_ff)
                S_RECOVER: begin
                    // wait out the power-on or reset recovery window
                    if (cnt_ff == 12'(adc_reset_pkg::RECOVERY_CYC - 1)) begin
                        state_ff <= S_IDLE;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 12'h001;
                    end
                end
                S_PIN: begin
                    // pin low long enough, plus margin for the synchroniser
                    if (cnt_ff == 12'(adc_reset_pkg::RESET_PIN_MIN_CYC + 1)) begin
                        state_ff <= S_RECOVER;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 12'h001;
                    end
                end
                S_IDLE: begin
                    if (hw_reset_req) begin
                        state_ff <= S_PIN;
                        cnt_ff <= '0;
                    end else if (cfg_req) begin
                        state_ff <= S_SHIFT;
                        tx_ff <= cfg_data;
                        cnt_ff <= '0;
                    end
                end
                S_SHIFT: begin
                    // rotate so the written word is whole again at frame end
                    tx_ff <= {tx_ff[10:0], tx_ff[11]};
                    rx_ff <= {rx_ff[10:0], link.serial_out_line};
                    if (cnt_ff == 12'(adc_reset_pkg::CFG_W - 1)) begin
                        state_ff <= S_END;
                    end
                    cnt_ff <= cnt_ff + 12'h001;
                end
                S_END: begin
                    cnt_ff <= '0;
                    // a cleared soft reset bit needs the recovery wait too
                    state_ff <= !tx_ff[adc_reset_pkg::SOFT_RESET_POS]
                        ? S_RECOVER : S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        conv_ff <= rst ? 1'b1 : !(state_ff == S_IDLE && convert_req && !cfg_req && !hw_reset_req);
    end

    assign link.reset_n_line = state_ff != S_PIN;
    assign link.frame_select_line = state_ff != S_SHIFT;
    assign link.shift_strobe = state_ff == S_SHIFT;
    assign link.serial_in_line = tx_ff[11];
    assign link.conversion_start_strobe = conv_ff;
    assign ready = state_ff == S_IDLE;
    assign read_data = rx_ff;
endmodule // adc_reset_host

//--- verif/adc_reset_asserts.sv
`timescale 1ns/1ps
module adc_reset_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n_line,
    input wire logic frame_select_line,
    input wire logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic conversion_start_strobe,
    input wire logic shift_strobe
);
    logic [9:0] since_ff;
    logic [4:0] bits_ff;
    logic frame_ff, pin_ff, last_ff, first_ff, soft_hit;
    // ----
    // wire-side reset tracking
    // ----
    // a soft reset is seen only as a whole 12-bit frame ending in a zero bit
    assign soft_hit = frame_select_line && !frame_ff && bits_ff == 5'h0C && !last_ff;
    always_ff @(posedge clk) begin
        frame_ff <= rst | frame_select_line;
        pin_ff <= rst | reset_n_line;
    end
    always_ff @(posedge clk) begin
        if (rst) bits_ff <= 5'h00;
        else if (!frame_select_line && shift_strobe) bits_ff <= bits_ff + 5'h01;
        else if (frame_ff) bits_ff <= 5'h00;
    end
    always_ff @(posedge clk) if (shift_strobe) last_ff <= serial_in_line;
    // counted from the pin's falling edge or a soft-reset frame end, the earliest point a reset is seen
    always_ff @(posedge clk) begin
        if (rst || (pin_ff && !reset_n_line) || soft_hit) since_ff <= 10'h000;
        else if (since_ff != 10'h3FF) since_ff <= since_ff + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (rst || !reset_n_line || soft_hit) first_ff <= 1'b1;
        else if (frame_select_line && !frame_ff) first_ff <= 1'b0;
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_pin_pulse_width: assert property ($fell(reset_n_line) |->
        (!reset_n_line) [*7] ##[1:3] reset_n_line) else $error("pin pulse width wrong");
    a_frame_after_reset: assert property ($fell(frame_select_line) |->
        since_ff >= adc_reset_pkg::RECOVERY_CYC) else $error("frame too soon");
    a_convert_after_reset: assert property ($fell(conversion_start_strobe) |->
        since_ff >= adc_reset_pkg::RECOVERY_CYC) else $error("convert too soon");
    a_strobe_one_cycle: assert property ($fell(conversion_start_strobe) |=>
        conversion_start_strobe) else $error("convert strobe too long");
    a_first_frame_ones: assert property (first_ff && !frame_select_line |->
        serial_out_line) else $error("first frame not all ones");
    a_frame_twelve_bits: assert property (frame_select_line && !frame_ff |->
        bits_ff == 5'h0C) else $error("frame bit count wrong");
    a_quiet_in_reset: assert property (!reset_n_line |->
        frame_select_line && conversion_start_strobe) else $error("traffic in pin reset");
    a_idle_after_rst: assert property ($fell(rst) |->
        reset_n_line && frame_select_line && conversion_start_strobe) else $error("not idle");
    cover property (soft_hit);
    cover property ($fell(reset_n_line));
    cover property ($fell(conversion_start_strobe));
endmodule // adc_reset_asserts

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_req = 1'b0;
    logic cfg_req = 1'b0;
    logic convert_req = 1'b0;
    logic [11:0] cfg_data = 12'h000;
    logic [15:0] analog_code = 16'h0000;
    logic [11:0] cfg_word, read_data, word;
    logic [15:0] result, code;
    logic result_valid, core_reset, conversion_clock, ready;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int t0 = 0;
    adc_reset_if link_if ();
    adc_reset_device adc_reset_device_i (.clk(clk), .rst(rst), .link(link_if.device),
        .analog_code(analog_code), .cfg_word(cfg_word), .result(result),
        .result_valid(result_valid), .core_reset(core_reset),
        .conversion_clock(conversion_clock));
    adc_reset_host adc_reset_host_i (.clk(clk), .rst(rst), .link(link_if.host),
        .hw_reset_req(hw_reset_req), .cfg_req(cfg_req), .cfg_data(cfg_data),
        .convert_req(convert_req), .ready(ready), .read_data(read_data));
    adc_reset_asserts adc_reset_asserts_i (.clk(clk), .rst(rst),
        .reset_n_line(link_if.reset_n_line), .frame_select_line(link_if.frame_select_line),
        .serial_in_line(link_if.serial_in_line), .serial_out_line(link_if.serial_out_line),
        .conversion_start_strobe(link_if.conversion_start_strobe),
        .shift_strobe(link_if.shift_strobe));
    always #2 clk = ~clk;
    // ----
    // helpers
    // ----
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ceiling is about five times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic req);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
        end
        req = 1'b1;
        cyc(1);
        req = 1'b0;
    endtask
    task automatic send_cfg(input logic [11:0] d);
        cfg_data = d;
        pulse(cfg_req);
        cyc(20);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(22766));
        cyc(6);
        rst = 1'b0;
        check("cfg default", 16'(adc_reset_pkg::CFG_DEFAULT), 16'(cfg_word));
        cyc(400);
        check("ready in recovery", 16'h0000, 16'(ready));
        // a request inside the recovery window must be dropped
        cfg_data = 12'h5A4;
        cfg_req = 1'b1;
        cyc(1);
        cfg_req = 1'b0;
        cyc(20);
        check("refused cfg", 16'h0FFF, 16'(cfg_word));
        for (int k = 0; k < 3; k++) begin
            word = 12'($urandom) | 12'h001;
            send_cfg(word);
            check("cfg write", 16'(word), 16'(cfg_word));
            if (k == 0) send_cfg(12'($urandom) & 12'hFFE);
            else if (k == 1) begin
                pulse(hw_reset_req);
                cyc(20);
            end else begin
                rst = 1'b1;
                cyc(6);
                rst = 1'b0;
                cyc(1);
            end
            check("cfg after reset", 16'h0FFF, 16'(cfg_word));
            check("soft bit", 16'h0001, 16'(cfg_word[0]));
            check("recovering", 16'h0000, 16'(ready));
            check("core reset released", 16'h0000, 16'(core_reset));
            word = 12'($urandom) | 12'h001;
            send_cfg(word);
            check("first readback", 16'h0FFF, 16'(read_data));
            check("cfg rewrite", 16'(word), 16'(cfg_word));
        end
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
            analog_code = code;
            pulse(convert_req);
            t0 = cycles;
            for (int n = 0; n < 600 && result_valid !== 1'b1; n++) cyc(1);
            check("result", code, result);
            // sixteen conversion clock periods plus launch latency
            check("conv time", 16'h0001, 16'((cycles - t0) >= 300 && (cycles - t0) <= 360));
        end
        send_cfg(12'($urandom) | 12'h001);
        check("result readback", 16'(code[15:4]), 16'(read_data));
        report_and_stop();
    end
endmodule // tb_top
